// ===== hdl/pwst_map.svh
`ifndef PWST_MAP_SVH
`define PWST_MAP_SVH
// Channel count.
`define PWST_NCH 2
// Register offsets.
`define PWST_OFS_PERIOD 8'h00
`define PWST_OFS_TBCTL 8'h04
`define PWST_OFS_TBCNT 8'h08
`define PWST_OFS_STATUS 8'h0c
`define PWST_OFS_DIR 8'h10
`define PWST_OFS_LATCH 8'h14
`define PWST_OFS_CH0 8'h20
`define PWST_OFS_CH1 8'h30
`define PWST_OFS_CCTL 4'h0
`define PWST_OFS_DH 4'h4
`define PWST_OFS_DL 4'h8
// Field positions.
`define PWST_TB_PS_LO 0
`define PWST_TB_PS_HI 1
`define PWST_TB_RUN 2
`define PWST_TB_POST_LO 3
`define PWST_TB_POST_HI 6
`define PWST_ST_FLAG 0
`define PWST_CC_EN 7
`define PWST_CC_OE 6
`define PWST_CC_OUT 5
`define PWST_CC_POL 4
`define PWST_DL_LO 6
`define PWST_DL_HI 7
// Reset values.
`define PWST_RST_PERIOD 8'hff
`define PWST_RST_DIR 2'h3
// Prescale terminal counts for ratios 1, 4, 16 and 64.
`define PWST_PS_LAST_1 6'h00
`define PWST_PS_LAST_4 6'h03
`define PWST_PS_LAST_16 6'h0f
`define PWST_PS_LAST_64 6'h3f
`endif

// ===== hdl/pwst_pkg.sv
package pwst_pkg;
    // Register select produced by the address decoder.
    typedef enum logic [3:0] {
        PWST_R_PERIOD, PWST_R_TBCTL, PWST_R_TBCNT, PWST_R_STATUS,
        PWST_R_DIR, PWST_R_LATCH, PWST_R_CCTL, PWST_R_DH, PWST_R_DL,
        PWST_R_NONE
    } pwst_reg_t;
    // Shared time base state.
    typedef struct packed {
        logic [5:0] pcnt;
        logic [1:0] fine;
        logic [7:0] count;
    } pwst_tb_st_t;
    // One channel's state.
    typedef struct packed {
        logic [9:0] duty;
        logic wave;
    } pwst_ch_st_t;
    // Register file and pin state.
    typedef struct packed {
        logic [7:0] period;
        logic tb_run;
        logic [1:0] ps_sel;
        logic [3:0] post_last;
        logic [3:0] post_cnt;
        logic match_flag;
        logic [1:0] dir;
        logic [1:0] latch;
        logic [1:0] en;
        logic [1:0] oe;
        logic [1:0] pol;
        logic [1:0][7:0] dh;
        logic [1:0][1:0] dl;
        logic [1:0] pin_out;
        logic [1:0] pin_oe;
        logic [31:0] rdata;
    } pwst_top_st_t;
endpackage

// ===== hdl/pwst_timebase.sv
`timescale 1ns/1ns
`include "pwst_map.svh"
module pwst_timebase import pwst_pkg::*; (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Control.
    input wire logic run,
    input wire logic hold,
    input wire logic [1:0] ps_sel,
    input wire logic [7:0] period,
    input wire logic cnt_we,
    input wire logic [7:0] cnt_wdata,
    // Time base out.
    output logic [9:0] tb,
    output logic [9:0] tb_next,
    output logic step,
    output logic reload
);
    pwst_tb_st_t st_ff;
    pwst_tb_st_t nxt_st;

    // Prescaler terminal count for each ratio select.
    function automatic logic [5:0] ps_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: ps_last = `PWST_PS_LAST_1;
            2'h1: ps_last = `PWST_PS_LAST_4;
            2'h2: ps_last = `PWST_PS_LAST_16;
            2'h3: ps_last = `PWST_PS_LAST_64;
        endcase
    endfunction

    // Fine bits advance per prescaled tick; the count advances when they wrap.
    always_comb begin
        nxt_st = st_ff;
        step = 1'b0;
        reload = 1'b0;
        if (cnt_we) begin
            nxt_st.count = cnt_wdata;
            nxt_st.fine = 2'h0;
            nxt_st.pcnt = 6'h00;
        end else if (!run) begin
            nxt_st.pcnt = 6'h00;
        end else if (!hold) begin
            if (st_ff.pcnt >= ps_last(ps_sel)) begin
                nxt_st.pcnt = 6'h00;
                step = 1'b1;
                nxt_st.fine = st_ff.fine + 2'h1;
                if (st_ff.fine == 2'h3) begin
                    if (st_ff.count == period) begin
                        nxt_st.count = 8'h00;
                        reload = 1'b1;
                    end else begin
                        nxt_st.count = st_ff.count + 8'h01;
                    end
                end
            end else begin
                nxt_st.pcnt = st_ff.pcnt + 6'h01;
            end
        end
        tb_next = {nxt_st.count, nxt_st.fine};
        tb = {st_ff.count, st_ff.fine};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ===== hdl/pwst_channel.sv
`timescale 1ns/1ns
`include "pwst_map.svh"
module pwst_channel import pwst_pkg::*; (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Time base.
    input wire logic step,
    input wire logic reload,
    input wire logic [9:0] tb_next,
    input wire logic [7:0] period,
    // Channel settings.
    input wire logic en,
    input wire logic [9:0] duty_new,
    // Waveform, active high, before polarity.
    output logic wave
);
    pwst_ch_st_t st_ff;
    pwst_ch_st_t nxt_st;
    logic [10:0] span;
    logic full;

    // A duty at or past the period never clears, giving a steady 100%.
    always_comb begin
        nxt_st = st_ff;
        span = {1'b0, period, 2'b00} + 11'h004;
        full = {1'b0, st_ff.duty} >= span;
        if (reload) begin
            nxt_st.duty = duty_new;
            nxt_st.wave = en && (duty_new != 10'h000);
        end else if (!en) begin
            nxt_st.wave = 1'b0;
        end else if (step && !full && tb_next == st_ff.duty) begin
            nxt_st.wave = 1'b0;
        end
        wave = st_ff.wave;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ===== hdl/pwst_top.sv
`timescale 1ns/1ns
`include "pwst_map.svh"
// How it works
// - Output goes inactive when time base equals duty.
// - Duty at or beyond period gives 100%.
// - Period match clears count, sets outputs unless new duty is zero, reloads duty.
// - Duty registers double buffered; compare uses copies.
// - Invert bit inverts the channel output.
// - All channels share timer and period limit.
// - Postscaler never affects period or duty.
// - Time base is count above two fine bits.
// - Period is four times limit plus one, prescaled.
// - Prescale 1:1 advances on every clock.
// - Limit 255 gives full ten-bit resolution.
// - Duty beyond period never clears the pin.
// - Sleep freezes counting and pin drive; bus writes still take effect.
// - Reset restores registers and makes pins inputs.
// - Pin follows port latch unless module enable and output enable both set.
// - Module enable bit, reset clear, disables channel.
// - Readable output-level bit shows current waveform after the invert bit.
// - Invert set means active low output.
module pwst_top import pwst_pkg::*; (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power state.
    input wire logic sleep,
    // Channel pins.
    output logic [`PWST_NCH-1:0] pin_out,
    output logic [`PWST_NCH-1:0] pin_oe
);
    pwst_top_st_t st_ff;
    pwst_top_st_t nxt_st;
    logic [9:0] tb;
    logic [9:0] tb_next;
    logic step;
    logic reload;
    logic [`PWST_NCH-1:0] wave;
    logic [`PWST_NCH-1:0] level;
    logic [`PWST_NCH-1:0][9:0] duty_new;
    pwst_reg_t rsel;
    logic rch;
    logic acc;
    logic wr;
    logic cnt_we;
    logic flag_set;
    logic flag_clr;

    // Address decode, shared by the read and write paths.
    function automatic pwst_reg_t decode(input logic [7:0] a);
        logic [7:0] base;
        base = {a[7:4], 4'h0};
        decode = PWST_R_NONE;
        unique case (a)
            `PWST_OFS_PERIOD: decode = PWST_R_PERIOD;
            `PWST_OFS_TBCTL: decode = PWST_R_TBCTL;
            `PWST_OFS_TBCNT: decode = PWST_R_TBCNT;
            `PWST_OFS_STATUS: decode = PWST_R_STATUS;
            `PWST_OFS_DIR: decode = PWST_R_DIR;
            `PWST_OFS_LATCH: decode = PWST_R_LATCH;
            default: begin
                if (base == `PWST_OFS_CH0 || base == `PWST_OFS_CH1) begin
                    if (a[3:0] == `PWST_OFS_CCTL) begin
                        decode = PWST_R_CCTL;
                    end else if (a[3:0] == `PWST_OFS_DH) begin
                        decode = PWST_R_DH;
                    end else if (a[3:0] == `PWST_OFS_DL) begin
                        decode = PWST_R_DL;
                    end
                end
            end
        endcase
    endfunction

    // One shared time base serves every channel.
    pwst_timebase u_tb (
        .pclk(pclk),
        .presetn(presetn),
        .run(st_ff.tb_run),
        .hold(sleep),
        .ps_sel(st_ff.ps_sel),
        .period(st_ff.period),
        .cnt_we(cnt_we),
        .cnt_wdata(pwdata[7:0]),
        .tb(tb),
        .tb_next(tb_next),
        .step(step),
        .reload(reload)
    );

    // Each channel has its own buffered duty but the common period.
    for (genvar i = 0; i < `PWST_NCH; i++) begin : g_ch
        assign duty_new[i] = {st_ff.dh[i], st_ff.dl[i]};
        pwst_channel u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .step(step),
            .reload(reload),
            .tb_next(tb_next),
            .period(st_ff.period),
            .en(st_ff.en[i]),
            .duty_new(duty_new[i]),
            .wave(wave[i])
        );
        // Polarity is applied after the compare so it never shifts edges.
        assign level[i] = wave[i] ^ st_ff.pol[i];
    end

    // Bus phases; the slave never inserts wait states.
    assign acc = psel && penable;
    assign pready = 1'b1;
    assign rsel = decode(paddr);
    assign rch = paddr[4];
    assign wr = acc && pwrite && (rsel != PWST_R_NONE);
    assign pslverr = acc && (rsel == PWST_R_NONE);
    assign cnt_we = wr && (rsel == PWST_R_TBCNT);
    assign prdata = st_ff.rdata;

    // The flag marks postscaled period matches and only software sees it.
    assign flag_set = reload && (st_ff.post_cnt == st_ff.post_last);
    assign flag_clr = wr && (rsel == PWST_R_STATUS) && pwdata[`PWST_ST_FLAG];

    // Register file, postscaler, read data and pin drive.
    always_comb begin
        nxt_st = st_ff;
        if (reload) begin
            if (st_ff.post_cnt == st_ff.post_last) begin
                nxt_st.post_cnt = 4'h0;
            end else begin
                nxt_st.post_cnt = st_ff.post_cnt + 4'h1;
            end
        end
        // A match landing on the clearing write still sets the flag.
        nxt_st.match_flag = (st_ff.match_flag && !flag_clr) || flag_set;
        if (wr) begin
            unique case (rsel)
                PWST_R_PERIOD: begin
                    nxt_st.period = pwdata[7:0];
                end
                PWST_R_TBCTL: begin
                    nxt_st.ps_sel = pwdata[`PWST_TB_PS_HI:`PWST_TB_PS_LO];
                    nxt_st.tb_run = pwdata[`PWST_TB_RUN];
                    nxt_st.post_last = pwdata[`PWST_TB_POST_HI:`PWST_TB_POST_LO];
                end
                PWST_R_DIR: begin
                    nxt_st.dir = pwdata[1:0];
                end
                PWST_R_LATCH: begin
                    nxt_st.latch = pwdata[1:0];
                end
                PWST_R_CCTL: begin
                    nxt_st.en[rch] = pwdata[`PWST_CC_EN];
                    nxt_st.oe[rch] = pwdata[`PWST_CC_OE];
                    nxt_st.pol[rch] = pwdata[`PWST_CC_POL];
                end
                PWST_R_DH: begin
                    nxt_st.dh[rch] = pwdata[7:0];
                end
                PWST_R_DL: begin
                    nxt_st.dl[rch] = pwdata[`PWST_DL_HI:`PWST_DL_LO];
                end
                default: begin
                    nxt_st.period = st_ff.period;
                end
            endcase
        end
        // Read data is captured in the setup cycle for the access phase.
        if (psel && !penable) begin
            nxt_st.rdata = 32'h0000_0000;
            unique case (rsel)
                PWST_R_PERIOD: nxt_st.rdata[7:0] = st_ff.period;
                PWST_R_TBCTL: begin
                    nxt_st.rdata[`PWST_TB_PS_HI:`PWST_TB_PS_LO] = st_ff.ps_sel;
                    nxt_st.rdata[`PWST_TB_RUN] = st_ff.tb_run;
                    nxt_st.rdata[`PWST_TB_POST_HI:`PWST_TB_POST_LO] = st_ff.post_last;
                end
                PWST_R_TBCNT: nxt_st.rdata[7:0] = tb[9:2];
                PWST_R_STATUS: nxt_st.rdata[`PWST_ST_FLAG] = st_ff.match_flag;
                PWST_R_DIR: nxt_st.rdata[1:0] = st_ff.dir;
                PWST_R_LATCH: nxt_st.rdata[1:0] = st_ff.latch;
                PWST_R_CCTL: begin
                    nxt_st.rdata[`PWST_CC_EN] = st_ff.en[rch];
                    nxt_st.rdata[`PWST_CC_OE] = st_ff.oe[rch];
                    nxt_st.rdata[`PWST_CC_OUT] = level[rch];
                    nxt_st.rdata[`PWST_CC_POL] = st_ff.pol[rch];
                end
                PWST_R_DH: nxt_st.rdata[7:0] = st_ff.dh[rch];
                PWST_R_DL: nxt_st.rdata[`PWST_DL_HI:`PWST_DL_LO] = st_ff.dl[rch];
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
        // In sleep the pins keep whatever they were driving.
        if (!sleep) begin
            for (int i = 0; i < `PWST_NCH; i++) begin
                nxt_st.pin_oe[i] = !st_ff.dir[i];
                if (st_ff.en[i] && st_ff.oe[i]) begin
                    nxt_st.pin_out[i] = level[i];
                end else begin
                    nxt_st.pin_out[i] = st_ff.latch[i];
                end
            end
        end
    end

    // Pins come straight from flip-flops so they never glitch.
    assign pin_out = st_ff.pin_out;
    assign pin_oe = st_ff.pin_oe;

    // Reset returns every register and leaves the pins as inputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.period <= `PWST_RST_PERIOD;
            st_ff.dir <= `PWST_RST_DIR;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ===== tb/pwst_top_chk.sv
`timescale 1ns/1ns
module pwst_top_chk (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Power and pins.
    input wire logic sleep,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe
);
    logic acc;
    logic hit;
    logic wdir;
    logic rch;
    // The channel blocks are sparse, so the holes between them must answer with an error.
    assign acc = psel && penable;
    assign hit = paddr[1:0] == 2'h0
        && (paddr <= 8'h14 || (paddr[7:5] == 3'h1 && paddr[3:0] <= 4'h8));
    assign wdir = acc && pwrite && paddr == 8'h10;
    assign rch = acc && !pwrite && paddr[7:5] == 3'h1;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_access: assert property (acc |-> pready)
        else $error("pready low in access");
    chk_err_unmapped: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (acc && hit |-> !pslverr)
        else $error("mapped access refused");
    chk_sleep_hold: assert property (sleep ##1 sleep |-> $stable(pin_out) && $stable(pin_oe))
        else $error("pins moved in sleep");
    chk_reset_pins: assert property ($rose(presetn) |-> pin_oe == 2'h0 && pin_out == 2'h0)
        else $error("pins not inputs after reset");
    chk_dir_cause: assert property ($changed(pin_oe) |-> $past(wdir, 1) || $past(wdir, 2))
        else $error("pin drive changed without direction write");
    chk_rdata_hold: assert property (acc ##1 !psel |-> $stable(prdata))
        else $error("read data did not stand");
    chk_duty_low_bits: assert property (rch && paddr[3:0] == 4'h8 |-> prdata[5:0] == 6'h0)
        else $error("duty low spare bits not zero");
    chk_ctl_bits: assert property (rch && paddr[3:0] == 4'h0 |-> prdata[3:0] == 4'h0)
        else $error("control spare bits not zero");
    cov_write: cover property (acc && pwrite);
    cov_refused: cover property (acc && pslverr);
    cov_sleep: cover property (sleep ##1 sleep);
    cov_edge: cover property ($rose(pin_out[0]));
endmodule
bind pwst_top pwst_top_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep(sleep), .pin_out(pin_out), .pin_oe(pin_oe));

// ===== tb/pwst_load.sv
`timescale 1ns/1ns
module pwst_load (
    // Pins from the block.
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    // Level seen on each pin.
    output logic [1:0] lvl
);
    // A released pin is pulled up, so it never shows a stale driven level.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            lvl[i] = pin_oe[i] ? pin_out[i] : 1'b1;
        end
    end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`include "pwst_map.svh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, sleep, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, t;
    logic [1:0] pin_out, pin_oe, lvl;
    logic [15:0] lf;
    logic [9:0] d0, d1;
    int n_fail, compares, per, nps, p, h0, h1;
    // Device and the load on its pins.
    pwst_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep(sleep), .pin_out(pin_out), .pin_oe(pin_oe));
    pwst_load load_u (.pin_out(pin_out), .pin_oe(pin_oe), .lvl(lvl));
    // Clock.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // High cycles over one whole period; any phase gives the same sum.
    function automatic int exp_hi(input int duty, input int lim, input int n, input logic inv);
        int full;
        int act;
        full = 4 * (lim + 1) * n;
        act = (duty >= 4 * (lim + 1)) ? full : duty * n;
        return inv ? full - act : act;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Pins are sampled on the falling edge, where they have settled.
    task automatic win(input int len);
        h0 = 0;
        h1 = 0;
        repeat (len) begin
            @(negedge pclk);
            h0 += (lvl[0] === 1'b1) ? 1 : 0;
            h1 += (lvl[1] === 1'b1) ? 1 : 0;
        end
        @(posedge pclk);
    endtask
    task automatic rst_cycle;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        check(32'(pin_oe), 32'h0, "pin_oe");
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `PWST_OFS_PERIOD, 32'h0);
        check(rd, 32'hff, "period");
        apb(1'b0, `PWST_OFS_DIR, 32'h0);
        check(rd, 32'h3, "direction");
        apb(1'b0, `PWST_OFS_CH1, 32'h0);
        check(rd, 32'h0, "control");
    endtask
    // Cut a hang short.
    initial begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        conclude();
    end
    initial begin
        {psel, penable, pwrite, sleep, paddr, pwdata} = '0;
        n_fail = 0;
        compares = 0;
        lf = 16'd55800;
        rst_cycle();
        apb(1'b1, 8'hfc, 32'h1);
        check(32'(er), 32'h1, "refusal");
        apb(1'b1, `PWST_OFS_CH0 + `PWST_OFS_DL, 32'hff);
        apb(1'b0, `PWST_OFS_CH0 + `PWST_OFS_DL, 32'h0);
        check(rd, 32'hc0, "duty low");
        apb(1'b1, `PWST_OFS_DIR, 32'h0);
        // Every prescale ratio, stopped and restarted in the documented order.
        for (int ps = 0; ps < 4; ps++) begin
            lf = lfsr(lf);
            p = 3 + int'(lf[1:0]);
            nps = 1 << (2 * ps);
            per = 4 * (p + 1) * nps;
            d0 = (ps == 0) ? 10'h0 : 10'(int'(lf[15:8]) % (4 * (p + 1)));
            d1 = (ps == 1) ? 10'(4 * (p + 1)) : (ps == 3) ? 10'h3ff : 10'(lf[9:4]);
            apb(1'b1, `PWST_OFS_TBCTL, 32'h0);
            apb(1'b1, `PWST_OFS_TBCNT, 32'h0);
            apb(1'b1, `PWST_OFS_PERIOD, 32'(p));
            apb(1'b1, `PWST_OFS_CH0 + `PWST_OFS_DH, 32'(d0[9:2]));
            apb(1'b1, `PWST_OFS_CH0 + `PWST_OFS_DL, 32'({d0[1:0], 6'h0}));
            apb(1'b1, `PWST_OFS_CH1 + `PWST_OFS_DH, 32'(d1[9:2]));
            apb(1'b1, `PWST_OFS_CH1 + `PWST_OFS_DL, 32'({d1[1:0], 6'h0}));
            apb(1'b1, `PWST_OFS_CH0, 32'hc0);
            apb(1'b1, `PWST_OFS_CH1, 32'hd0);
            apb(1'b1, `PWST_OFS_TBCTL, 32'({lf[6:3], 1'b1, 2'(ps)}));
            repeat (2 * per + 8) @(posedge pclk);
            win(per);
            check(h0, exp_hi(d0, p, nps, 1'b0), "pin0 high");
            check(h1, exp_hi(d1, p, nps, 1'b1), "pin1 high");
            if (ps == 1) begin
                apb(1'b0, `PWST_OFS_CH1, 32'h0);
                check(rd, 32'hd0, "level");
            end
        end
        // Sleep holds the count.
        sleep <= 1'b1;
        apb(1'b0, `PWST_OFS_TBCNT, 32'h0);
        t = rd;
        repeat (200) @(posedge pclk);
        apb(1'b0, `PWST_OFS_TBCNT, 32'h0);
        check(rd, t, "sleep count");
        // No period match can come in sleep, so a cleared flag stays clear.
        apb(1'b1, `PWST_OFS_STATUS, 32'h1);
        apb(1'b0, `PWST_OFS_STATUS, 32'h0);
        check(rd, 32'h0, "match flag");
        sleep <= 1'b0;
        // Pin 0 handed back to the port latch, then pin 1 released to the pull-up.
        apb(1'b1, `PWST_OFS_LATCH, 32'h1);
        apb(1'b1, `PWST_OFS_CH0, 32'h80);
        win(50);
        check(h0, 32'd50, "latch pin");
        apb(1'b1, `PWST_OFS_LATCH, 32'h0);
        apb(1'b1, `PWST_OFS_CH0, 32'h40);
        apb(1'b1, `PWST_OFS_DIR, 32'h2);
        win(50);
        check(h0, 32'd0, "idle pin");
        check(h1, 32'd50, "released pin");
        rst_cycle();
        conclude();
    end
endmodule
